// ---- inc/sciagg_defs.svh ----
/*
 * constants for the event aggregator: widths and reset values.
 * assumes inclusion by bare name from design and bench files.
 */
`ifndef SCIAGG_DEFS_SVH
`define SCIAGG_DEFS_SVH
// ==========================================================
// widths
`define SCIAGG_PM1_W 16
`define SCIAGG_GPE0_W 8
`define SCIAGG_GPE1_W 8
`define SCIAGG_GPE_MAX 256
// ==========================================================
// reset values
`define SCIAGG_STS_RST 1'B0
`define SCIAGG_EN_RST 1'B0
`define SCIAGG_SCI_RST 1'B0
`endif

// ---- inc/sciagg_pkg.sv ----
/*
 * types for the event aggregator.
 * assumes sciagg_defs.svh on the include path.
 */
`default_nettype none
package sciagg_pkg;
    // ==========================================================
    // event sense of one general-purpose input
    typedef enum logic {
        SCIAGG_SENSE_LEVEL = 1'B0,
        SCIAGG_SENSE_EDGE = 1'B1
    } sciagg_sense_t;
endpackage : sciagg_pkg
`default_nettype wire

// ---- src/sciagg_top.sv ----
/*
 * event aggregator: pm1 a/b and gpe0/gpe1 status/enable into one sci level.
 * assumes synchronous software strobes on i_clk_sys; event inputs are async pins.
 */
// Overview of operation
// - sci while any enabled pm1 status set
// - pm1 status and enable in a,b halves
// - one enable per gpe status bit
// - at most 256 gpe bits overall
// - sci while any enabled gpe status set
// - sci is a shareable level output
// - two gpe blocks, each status and enable
// - gpe status latches until software clears
// - write one clears status, enables read/write
// - each gpe input edge or level sensed
`include "sciagg_defs.svh"
`default_nettype none
module sciagg_top #(
    parameter int PM1_W = `SCIAGG_PM1_W,
    parameter int GPE0_W = `SCIAGG_GPE0_W,
    parameter int GPE1_W = `SCIAGG_GPE1_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [PM1_W-1:0] i_pm1a_evt,
    input wire logic [PM1_W-1:0] i_pm1b_evt,
    input wire logic [PM1_W-1:0] i_pm1a_sts_clr,
    input wire logic [PM1_W-1:0] i_pm1b_sts_clr,
    input wire logic i_pm1a_en_we,
    input wire logic [PM1_W-1:0] i_pm1a_en_wdata,
    input wire logic i_pm1b_en_we,
    input wire logic [PM1_W-1:0] i_pm1b_en_wdata,
    input wire logic [GPE0_W-1:0] i_gpe0_evt,
    input wire logic [GPE1_W-1:0] i_gpe1_evt,
    input wire logic [GPE0_W-1:0] i_gpe0_sense,
    input wire logic [GPE1_W-1:0] i_gpe1_sense,
    input wire logic [GPE0_W-1:0] i_gpe0_sts_clr,
    input wire logic [GPE1_W-1:0] i_gpe1_sts_clr,
    input wire logic i_gpe0_en_we,
    input wire logic [GPE0_W-1:0] i_gpe0_en_wdata,
    input wire logic i_gpe1_en_we,
    input wire logic [GPE1_W-1:0] i_gpe1_en_wdata,
    output logic [PM1_W-1:0] o_pm1a_sts,
    output logic [PM1_W-1:0] o_pm1b_sts,
    output logic [PM1_W-1:0] o_pm1a_en,
    output logic [PM1_W-1:0] o_pm1b_en,
    output logic [GPE0_W-1:0] o_gpe0_sts,
    output logic [GPE1_W-1:0] o_gpe1_sts,
    output logic [GPE0_W-1:0] o_gpe0_en,
    output logic [GPE1_W-1:0] o_gpe1_en,
    output logic o_sci
);
    import sciagg_pkg::*;

    // ==========================================================
    // sizes: pm1 halves side by side, gpe blocks side by side
    localparam int PMW = 2 * PM1_W;
    // total gpe width, kept within the cap by the checker
    localparam int GW = GPE0_W + GPE1_W;

    // ==========================================================
    // flattened views of the pins and strobes
    wire [PMW-1:0] pm_evt = {i_pm1b_evt, i_pm1a_evt};
    wire [PMW-1:0] pm_clr = {i_pm1b_sts_clr, i_pm1a_sts_clr};
    wire [GW-1:0] g_evt = {i_gpe1_evt, i_gpe0_evt};
    wire [GW-1:0] g_sense = {i_gpe1_sense, i_gpe0_sense};
    wire [GW-1:0] g_clr = {i_gpe1_sts_clr, i_gpe0_sts_clr};

    // ==========================================================
    // pm1 pin synchronisers; third stage holds the last level
    // a pin high through reset shows as an edge after release
    logic [PMW-1:0] pm_s1_reg;
    logic [PMW-1:0] pm_s2_reg;
    logic [PMW-1:0] pm_s3_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pm_s1_reg <= '0;
            pm_s2_reg <= '0;
            pm_s3_reg <= '0;
        end else begin
            pm_s1_reg <= pm_evt;
            pm_s2_reg <= pm_s1_reg;
            pm_s3_reg <= pm_s2_reg;
        end
    end

    // ==========================================================
    // gpe pin synchronisers; third stage holds the last level
    logic [GW-1:0] g_s1_reg;
    logic [GW-1:0] g_s2_reg;
    logic [GW-1:0] g_s3_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            g_s1_reg <= '0;
            g_s2_reg <= '0;
            g_s3_reg <= '0;
        end else begin
            g_s1_reg <= g_evt;
            g_s2_reg <= g_s1_reg;
            g_s3_reg <= g_s2_reg;
        end
    end

    // ==========================================================
    // pm1 set: rising edge only
    wire [PMW-1:0] pm_set = pm_s2_reg & ~pm_s3_reg;

    // ==========================================================
    // pm1 status: write one clears, set wins over clear
    logic [PMW-1:0] pm_sts_reg;
    wire [PMW-1:0] pm_keep = pm_sts_reg & ~pm_clr;
    wire [PMW-1:0] pm_sts_next = pm_set | pm_keep;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pm_sts_reg <= {PMW{`SCIAGG_STS_RST}};
        end else begin
            pm_sts_reg <= pm_sts_next;
        end
    end

    // ==========================================================
    // pm1 enables: each half loads whole from its own strobe
    logic [PMW-1:0] pm_en_reg;
    wire [PM1_W-1:0] pm1a_en_old = pm_en_reg[PM1_W-1:0];
    wire [PM1_W-1:0] pm1b_en_old = pm_en_reg[PMW-1:PM1_W];
    wire [PM1_W-1:0] pm1a_en_next = i_pm1a_en_we ? i_pm1a_en_wdata : pm1a_en_old;
    wire [PM1_W-1:0] pm1b_en_next = i_pm1b_en_we ? i_pm1b_en_wdata : pm1b_en_old;
    wire [PMW-1:0] pm_en_next = {pm1b_en_next, pm1a_en_next};
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pm_en_reg <= {PMW{`SCIAGG_EN_RST}};
        end else begin
            pm_en_reg <= pm_en_next;
        end
    end

    // ==========================================================
    // gpe set per bit: rising edge or high level, by sense bit
    logic [GW-1:0] g_set;
    genvar gi;
    generate
        for (gi = 0; gi < GW; gi++) begin : g_bit
            wire g_rise = g_s2_reg[gi] & ~g_s3_reg[gi];
            wire g_edge = (g_sense[gi] == SCIAGG_SENSE_EDGE);
            assign g_set[gi] = g_edge ? g_rise : g_s2_reg[gi];
        end
    endgenerate

    // ==========================================================
    // gpe status: latches until a one is written to clear it
    // a level bit with its pin still high is set again at once
    logic [GW-1:0] g_sts_reg;
    wire [GW-1:0] g_keep = g_sts_reg & ~g_clr;
    wire [GW-1:0] g_sts_next = g_set | g_keep;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            g_sts_reg <= {GW{`SCIAGG_STS_RST}};
        end else begin
            g_sts_reg <= g_sts_next;
        end
    end

    // ==========================================================
    // gpe enables: one per status bit, each block loads whole
    logic [GW-1:0] g_en_reg;
    wire [GPE0_W-1:0] gpe0_en_old = g_en_reg[GPE0_W-1:0];
    wire [GPE1_W-1:0] gpe1_en_old = g_en_reg[GW-1:GPE0_W];
    wire [GPE0_W-1:0] gpe0_en_next = i_gpe0_en_we ? i_gpe0_en_wdata : gpe0_en_old;
    wire [GPE1_W-1:0] gpe1_en_next = i_gpe1_en_we ? i_gpe1_en_wdata : gpe1_en_old;
    wire [GW-1:0] g_en_next = {gpe1_en_next, gpe0_en_next};
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            g_en_reg <= {GW{`SCIAGG_EN_RST}};
        end else begin
            g_en_reg <= g_en_next;
        end
    end

    // ==========================================================
    // pending masks: status and enable paired bit for bit
    wire [PMW-1:0] pm_pend = pm_sts_next & pm_en_next;
    wire [GW-1:0] g_pend = g_sts_next & g_en_next;
    wire pm1a_hit = |pm_pend[PM1_W-1:0];
    wire pm1b_hit = |pm_pend[PMW-1:PM1_W];
    wire gpe0_hit = |g_pend[GPE0_W-1:0];
    wire gpe1_hit = |g_pend[GW-1:GPE0_W];
    wire sci_next = pm1a_hit | pm1b_hit | gpe0_hit | gpe1_hit;

    // ==========================================================
    // sci level: registered from next values, so it moves
    // on the same edge as the status and enable outputs
    logic sci_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sci_reg <= `SCIAGG_SCI_RST;
        end else begin
            sci_reg <= sci_next;
        end
    end

    // ==========================================================
    // status outputs
    assign o_pm1a_sts = pm_sts_reg[PM1_W-1:0];
    assign o_pm1b_sts = pm_sts_reg[PMW-1:PM1_W];
    assign o_gpe0_sts = g_sts_reg[GPE0_W-1:0];
    assign o_gpe1_sts = g_sts_reg[GW-1:GPE0_W];

    // ==========================================================
    // enable outputs
    assign o_pm1a_en = pm_en_reg[PM1_W-1:0];
    assign o_pm1b_en = pm_en_reg[PMW-1:PM1_W];
    assign o_gpe0_en = g_en_reg[GPE0_W-1:0];
    assign o_gpe1_en = g_en_reg[GW-1:GPE0_W];

    // ==========================================================
    // interrupt output: a plain level, shareable by the receiver
    assign o_sci = sci_reg;
endmodule : sciagg_top
`default_nettype wire

// ---- testbench/sciagg_assertions.sv ----
/* sciagg_top port checker; bound below */
`default_nettype none
module sciagg_chk #(parameter int PM1_W = 16, GPE0_W = 8, GPE1_W = 8) (
    input wire logic i_clk_sys, i_rst_n, i_pm1a_en_we, i_gpe0_en_we, o_sci,
    input wire logic [PM1_W-1:0] i_pm1a_sts_clr, i_pm1a_en_wdata, o_pm1a_sts,
    input wire logic [PM1_W-1:0] o_pm1b_sts, o_pm1a_en, o_pm1b_en,
    input wire logic [GPE0_W-1:0] i_gpe0_sts_clr, i_gpe0_en_wdata, o_gpe0_sts, o_gpe0_en,
    input wire logic [GPE1_W-1:0] o_gpe1_sts, o_gpe1_en);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire logic any_on = |(o_pm1a_sts & o_pm1a_en) | |(o_pm1b_sts & o_pm1b_en)
        | |(o_gpe0_sts & o_gpe0_en) | |(o_gpe1_sts & o_gpe1_en);
    a_sci_level: assert property (o_sci == any_on)
        else $error("sci level wrong");
    a_gpe0_load: assert property (i_gpe0_en_we |=> o_gpe0_en == $past(i_gpe0_en_wdata))
        else $error("gpe0 enable load");
    a_gpe0_hold: assert property (!i_gpe0_en_we |=> $stable(o_gpe0_en))
        else $error("gpe0 enable moved");
    a_pm1a_load: assert property (i_pm1a_en_we |=> o_pm1a_en == $past(i_pm1a_en_wdata))
        else $error("pm1a enable load");
    a_pm1a_hold: assert property (!i_pm1a_en_we |=> $stable(o_pm1a_en))
        else $error("pm1a enable moved");
    a_gpe0_latch: assert property ((~o_gpe0_sts & $past(o_gpe0_sts & ~i_gpe0_sts_clr)) == 0)
        else $error("gpe0 status fell");
    a_pm1a_latch: assert property ((~o_pm1a_sts & $past(o_pm1a_sts & ~i_pm1a_sts_clr)) == 0)
        else $error("pm1a status fell");
    a_rst_quiet: assert property (disable iff (1'B0) !i_rst_n |-> !o_sci && !o_gpe0_en)
        else $error("reset not clear");
    a_gpe_cap: assert property ($bits(o_gpe0_sts) + $bits(o_gpe1_sts) <= 256)
        else $error("gpe width over cap");
endmodule : sciagg_chk
bind sciagg_top sciagg_chk #(.PM1_W(PM1_W), .GPE0_W(GPE0_W), .GPE1_W(GPE1_W)) u_sciagg_chk (.*);
`default_nettype wire

// ---- testbench/sciagg_pic_model.sv ----
/* interrupt controller model; samples sci on the bench clock */
`default_nettype none
module sciagg_pic_model (
    input wire logic i_clk_sys,
    input wire logic i_sci,
    output logic o_pending);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_clk_sys) o_pending <= i_sci;
endmodule : sciagg_pic_model
`default_nettype wire

// ---- testbench/sciagg_tb_top.sv ----
/* bench for sciagg_top; needs the design, model and checker */
`default_nettype none
module sciagg_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'B1, i_rst_n = 1'B1, i_pm1a_en_we = 0, i_pm1b_en_we = 0, o_sci, pend;
    logic i_gpe0_en_we = 0, i_gpe1_en_we = 0;
    logic [15:0] i_pm1a_evt = '0, i_pm1b_evt = '0, i_pm1a_sts_clr = '0, i_pm1b_sts_clr = '0;
    logic [15:0] i_pm1a_en_wdata = '0, i_pm1b_en_wdata = '0, o_pm1a_sts, o_pm1b_sts;
    logic [15:0] o_pm1a_en, o_pm1b_en;
    logic [7:0] i_gpe0_evt = '0, i_gpe1_evt = '0, i_gpe0_sense = '1, i_gpe1_sense = '0;
    logic [7:0] i_gpe0_sts_clr = '0, i_gpe1_sts_clr = '0, i_gpe0_en_wdata = '0;
    logic [7:0] i_gpe1_en_wdata = '0, o_gpe0_sts, o_gpe1_sts, o_gpe0_en, o_gpe1_en;
    int bad_count = 0, num_checks = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    sciagg_top u_sciagg_top (.*);
    sciagg_pic_model u_sciagg_pic_model (.i_clk_sys(i_clk_sys), .i_sci(o_sci), .o_pending(pend));
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic nc(int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : nc
    task automatic wsci;
        int k;
        for (k = 0; k < 8 && o_sci !== 1'B1; k++) nc(1);
        if (o_sci !== 1'B1) begin
            bad_count++;
            summarize();
        end
    endtask : wsci
    task automatic t_edge;
        {i_gpe0_en_we, i_gpe0_en_wdata, i_gpe0_evt} = {1'B1, 8'H01, 8'H01};
        nc(1);
        {i_gpe0_en_we, i_gpe0_evt} = '0;
        wsci();
        chk("gpe0 sts", 16'H0001, 16'(o_gpe0_sts));
        chk("gpe0 en", 16'H0001, 16'(o_gpe0_en));
        i_gpe0_sts_clr = 8'H01;
        nc(1);
        i_gpe0_sts_clr = 8'H00;
        nc(2);
        chk("gpe0 clr", 16'H0000, {o_gpe0_sts, 6'H0, o_sci, pend});
    endtask : t_edge
    task automatic t_level;
        {i_gpe1_en_we, i_gpe1_en_wdata, i_gpe1_evt} = {1'B1, 8'H08, 8'H08};
        nc(1);
        i_gpe1_en_we = 0;
        wsci();
        i_gpe1_sts_clr = 8'H08;
        nc(1);
        i_gpe1_sts_clr = 8'H00;
        nc(1);
        chk("gpe1 level", 16'H0108, {7'H0, o_sci, o_gpe1_sts});
        i_gpe1_evt = 8'H00;
        nc(3);
        i_gpe1_sts_clr = 8'H08;
        nc(1);
        i_gpe1_sts_clr = 8'H00;
        chk("gpe1 clr", 16'H0000, {7'H0, o_sci, o_gpe1_sts});
    endtask : t_level
    task automatic t_pm1;
        {i_pm1b_en_we, i_pm1b_en_wdata, i_pm1b_evt, i_pm1a_evt} = {1'B1, 16'H8000, 16'H8000, 16'H1};
        nc(1);
        {i_pm1b_en_we, i_pm1b_evt, i_pm1a_evt} = '0;
        wsci();
        chk("pm1 sts", 16'H8001, o_pm1b_sts | o_pm1a_sts);
        {i_pm1b_en_we, i_pm1b_en_wdata, i_pm1a_en_we, i_pm1a_en_wdata} = {17'H10000, 17'H10001};
        nc(1);
        {i_pm1b_en_we, i_pm1a_en_we, i_pm1a_sts_clr} = {2'H0, 16'H0001};
        chk("pm1 a on", 16'H0001, 16'(o_sci));
        nc(1);
        i_pm1a_sts_clr = '0;
        chk("pm1 a clr", 16'H0000, 16'(o_sci));
    endtask : t_pm1
    task automatic t_reset;
        {i_gpe0_en_we, i_gpe0_en_wdata, i_gpe0_evt} = {1'B1, 8'H02, 8'H02};
        nc(1);
        {i_gpe0_en_we, i_gpe0_evt} = '0;
        wsci();
        nc(1);
        chk("pic pending", 16'H0001, 16'(pend));
        i_rst_n = 1'B0;
        nc(1);
        chk("reset sts en", 16'H0000, {o_gpe0_sts, o_gpe0_en});
        chk("reset sci", 16'H0000, 16'(o_sci));
        i_rst_n = 1'B1;
        nc(2);
        chk("after reset", 16'H0000, {7'H0, o_sci, o_gpe0_sts});
    endtask : t_reset
    initial begin
        nc(1);
        i_rst_n = 1'B0;
        nc(12);
        i_rst_n = 1'B1;
        nc(2);
        t_edge();
        t_level();
        t_pm1();
        t_reset();
        summarize();
    end
endmodule : sciagg_tb_top
`default_nettype wire
